// File: logic/clock_rate_meter.sv
// Synchroniser and period meter for one external wordclock pin
`include "wordclock_consts.svh"

module clock_rate_meter (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic clk_pin, // Wordclock pin, foreign domain
    output wordclock_pkg::meter_s meas // Level, presence, period
);
    import wordclock_pkg::*;

    logic [2:0] sync_q;
    logic level_q;
    logic present_q;
    logic [10:0] cnt_q;
    logic [10:0] period_q;
    logic stable;
    logic rise;
    logic timeout;

    // A change counts only once the second and third stages agree
    assign stable = sync_q[1] == sync_q[2];
    assign rise = stable && sync_q[2] && !level_q;
    assign timeout = cnt_q == 11'(`PER_TIMEOUT);

    // Three-stage synchroniser and filtered level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q <= 3'h0;
            level_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], clk_pin};
            if (stable) begin
                level_q <= sync_q[2];
            end
        end
    end

    // Period between rising edges; a silent pin times out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 11'h000;
            period_q <= 11'h000;
            present_q <= 1'b0;
        end else if (rise) begin
            period_q <= cnt_q;
            cnt_q <= 11'h001;
            present_q <= 1'b1;
        end else if (timeout) begin
            period_q <= 11'h000;
            present_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 11'h001;
        end
    end

    // Accepted rate band, with the first period after silence discarded
    assign meas = '{level: level_q, present: present_q,
        valid: present_q && period_q >= 11'(`PER_MIN) && period_q <= 11'(`PER_MAX),
        rise: rise, period: period_q};

endmodule : clock_rate_meter

// File: logic/word_shortener.sv
// Word length reduction with optional pseudorandom dither, one stereo pair
`include "wordclock_consts.svh"

module word_shortener #(
    parameter logic [4:0] CAP = 5'd24 // Widest word this output carries
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic tick, // Sample strobe
    input wordclock_pkg::dither_cfg_s cfg, // Dither and word length
    input wire logic [27:0] rnd, // Pseudorandom word
    input wordclock_pkg::mix_pair_s smp, // Full precision pair
    output wordclock_pkg::out_pair_s q // Shortened pair, MSB aligned
);
    import wordclock_pkg::*;

    logic [4:0] keep;
    logic [27:0] left_w;
    logic [27:0] right_w;

    // Shorten one sample; dither compares the discarded part with noise
    function automatic logic [27:0] shorten(input logic signed [27:0] s,
        input logic [4:0] bits, input logic dith, input logic [27:0] r);
        logic [4:0] drop;
        logic [27:0] mask;
        logic signed [27:0] kept;
        logic signed [27:0] top;
        logic up;
        drop = 5'd28 - bits;
        mask = ~(28'hFFFFFFF << drop);
        kept = s >>> drop;
        top = 28'sh7FFFFFF >>> drop;
        up = dith && ((28'(s) & mask) > (r & mask));
        // Full scale stays put rather than wrapping negative
        if (up && kept != top) begin
            kept = kept + 28'sd1;
        end
        return 28'(kept <<< drop);
    endfunction : shorten

    // Requested length, never wider than the output can carry
    assign keep = (cfg.len == WL_16) ? 5'd16 :
        (cfg.len == WL_20 || CAP < 5'd24) ? 5'd20 : 5'd24;

    // Right channel takes inverted noise so the pair is not correlated
    assign left_w = shorten(smp.left, keep, cfg.dither, rnd);
    assign right_w = shorten(smp.right, keep, cfg.dither, ~rnd);

    // Output pair register, loaded once per sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else if (tick) begin
            q <= '{left: left_w[27:4], right: right_w[27:4]};
        end
    end

endmodule : word_shortener

// File: logic/wordclock_select_dither_out.sv
// Wordclock source selection, lock tracking and digital output shaping
//
// Added by the designer: the register addresses and the APB register port.
`include "wordclock_consts.svh"

module wordclock_select_dither_out (
    input wire logic pclk, // System clock, 20 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic stereo_digital_input_clock, // Clock from stereo input
    input wire logic dedicated_clock_input, // Dedicated wordclock pin
    input wire logic [3:0] card_clock_in, // Card input pair clocks
    input wordclock_pkg::mix_pair_s stereo_bus_mix, // Direct bus tap
    input wordclock_pkg::mix_pair_s after_fader_tap, // After stereo fader
    input wordclock_pkg::mix_pair_s [3:0] card_mix, // Card output pairs
    output logic wordclock_out, // Wordclock drive
    output logic wordclock_out_en, // High while acting as master
    output logic sample_tick, // One pulse per sample
    output logic clock_locked, // Locked to chosen source
    output logic unlocked_flag, // Global unlock indication
    output wordclock_pkg::rate_code_e sample_rate_indicator, // Rate code
    output logic stereo_sync_warning, // Stereo input out of sync
    output logic card_sync_warning, // A card input out of sync
    output wordclock_pkg::out_pair_s stereo_output_pair, // 24-bit pair
    output logic [39:0] consumer_output_pair, // 20-bit pair {L,R}
    output wordclock_pkg::out_pair_s [3:0] card_output // Card pairs
);
    import wordclock_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    logic [31:0] clk_ctrl_q;
    logic [31:0] out_ctrl_q;
    logic [31:0] prdata_q;
    logic [25:0] nco_q;
    logic wc_int_q;
    logic wc_out_q;
    logic [2:0] lock_cnt_q;
    logic tick_q;
    logic [31:0] lfsr_q;
    rate_code_e rate_q;
    logic swarn_q;
    logic cwarn_q;
    search_state_e scan_q;
    search_state_e scan_d;
    logic [2:0] idx_q;
    logic found_q;
    logic [2:0] prop_q;
    meter_s meas [5:0];
    src_state_e state_w [5:0];
    logic [11:0] state_bits;
    logic [5:0] cand;
    logic [5:0] notsync;
    logic [5:0] pins;

    // ****************************************
    // Helpers
    // ****************************************

    // Periods within a small tolerance count as the same clock
    function automatic logic in_sync(input logic [10:0] a, input logic [10:0] b);
        in_sync = ((a > b) ? (a - b) : (b - a)) <= 11'(`SYNC_TOL);
    endfunction : in_sync

    // ****************************************
    // Register bus decode
    // ****************************************
    logic hit_clk;
    logic hit_out;
    logic hit_st;
    logic mapped;
    logic wr_en;
    logic search_go;
    clk_src_e src;
    logic flip;
    clk_src_e new_src;
    logic src_change;

    assign hit_clk = paddr == `OFS_CLK_CTRL;
    assign hit_out = paddr == `OFS_OUT_CTRL;
    assign hit_st = paddr == `OFS_STATUS;
    assign mapped = hit_clk || hit_out || hit_st;
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;
    assign search_go = wr_en && hit_clk && pwdata[`CC_SEARCH_BIT];
    assign src = clk_src_e'(clk_ctrl_q[`CC_SRC_LSB +: 3]);
    assign flip = clk_ctrl_q[`CC_FLIP_BIT];
    assign new_src = clk_src_e'(pwdata[`CC_SRC_LSB +: 3]);
    assign src_change = wr_en && hit_clk && new_src != src;

    // Control registers; search start is a write-only strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_ctrl_q <= `CC_RESET;
            out_ctrl_q <= `OC_RESET;
        end else if (wr_en && hit_clk) begin
            clk_ctrl_q <= pwdata & `CC_WMASK;
        end else if (wr_en && hit_out) begin
            out_ctrl_q <= pwdata & `OC_WMASK;
        end
    end

    // Status word assembled from live state
    logic [31:0] status_w;
    assign status_w = {4'h0, state_bits, 5'h00, prop_q, 1'b0, found_q,
        scan_q != SCAN_IDLE, cwarn_q, swarn_q, clock_locked, rate_q};

    // Read data captured in the setup cycle, valid in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= hit_clk ? clk_ctrl_q : hit_out ? out_ctrl_q :
                hit_st ? status_w : 32'h0000_0000;
        end
    end

    // ****************************************
    // External clock meters
    // ****************************************
    assign pins = {card_clock_in, dedicated_clock_input, stereo_digital_input_clock};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_meter
            clock_rate_meter u_meter (
                .pclk(pclk),
                .presetn(presetn),
                .clk_pin(pins[gi]),
                .meas(meas[gi])
            );
        end
    endgenerate

    // ****************************************
    // Internal generator
    // ****************************************
    logic [25:0] nco_inc;
    logic [25:0] nco_sum;
    logic nco_wrap;
    logic int_tick;

    // Fractional accumulator keeps the average rate exact at 20 MHz
    assign nco_inc = (src == SRC_INT_44K1) ? 26'(2 * `INT_RATE_A_HZ) :
        26'(2 * `INT_RATE_B_HZ);
    assign nco_sum = nco_q + nco_inc;
    assign nco_wrap = nco_sum >= 26'(`PCLK_HZ);
    assign int_tick = nco_wrap && !wc_int_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nco_q <= 26'h0000000;
            wc_int_q <= 1'b0;
        end else if (nco_wrap) begin
            nco_q <= nco_sum - 26'(`PCLK_HZ);
            wc_int_q <= !wc_int_q;
        end else begin
            nco_q <= nco_sum;
        end
    end

    // ****************************************
    // Source selection and lock
    // ****************************************
    logic is_ext;
    logic [2:0] ext_idx;
    meter_s sel_meas;
    logic sel_ok;
    logic sel_tick;
    logic [10:0] master_per;

    assign is_ext = src >= SRC_STEREO_IN;
    assign ext_idx = is_ext ? 3'(src - SRC_STEREO_IN) : 3'h0;
    assign sel_meas = meas[ext_idx];
    assign sel_ok = !is_ext || (sel_meas.valid
        && (ext_idx != 3'h0 || flip));
    assign sel_tick = is_ext ? sel_meas.rise : int_tick;
    assign master_per = !is_ext ? ((src == SRC_INT_44K1) ? 11'(`PER_INT_A) :
        11'(`PER_INT_B)) : sel_meas.period;
    assign clock_locked = lock_cnt_q == 3'(`LOCK_PERIODS);
    assign unlocked_flag = !clock_locked;

    // Lock after several good periods; selection change starts over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt_q <= 3'h0;
        end else if (src_change || !sel_ok) begin
            lock_cnt_q <= 3'h0;
        end else if (sel_tick && !clock_locked) begin
            lock_cnt_q <= lock_cnt_q + 3'h1;
        end
    end

    // Wordclock drive follows the generator as master and the chosen input's level otherwise; enabled only as master
    assign wordclock_out = wc_out_q;
    assign wordclock_out_en = !is_ext;
    assign sample_tick = tick_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wc_out_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            wc_out_q <= is_ext ? sel_meas.level : wc_int_q;
            tick_q <= sel_tick && clock_locked;
        end
    end

    // ****************************************
    // Source states and warnings
    // ****************************************
    generate
        for (gi = 0; gi < 6; gi++) begin : g_state
            // Not synchronous means a present clock out of the rate band or, while locked, off the master period
            assign state_w[gi] = (is_ext && ext_idx == 3'(gi) && clock_locked) ?
                ST_LOCKED : !meas[gi].present ? ST_NONE :
                (meas[gi].valid && (!clock_locked ||
                in_sync(meas[gi].period, master_per))) ? ST_USABLE :
                ST_NOT_SYNC;
            assign state_bits[2*gi +: 2] = state_w[gi];
            assign notsync[gi] = state_w[gi] == ST_NOT_SYNC;
            assign cand[gi] = meas[gi].valid && (gi != 0 || flip);
        end
    endgenerate

    // Rate code from the master period; unlock overrides everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_q <= RATE_UNLOCK;
            swarn_q <= 1'b0;
            cwarn_q <= 1'b0;
        end else begin
            rate_q <= !clock_locked ? RATE_UNLOCK :
                (master_per < 11'(`PER_SPLIT_48)) ? RATE_48K :
                (master_per < 11'(`PER_SPLIT_32)) ? RATE_44K1 : RATE_32K;
            swarn_q <= clk_ctrl_q[`CC_SWARN_BIT] && notsync[0];
            cwarn_q <= clk_ctrl_q[`CC_CWARN_BIT] && |notsync[5:2];
        end
    end

    assign sample_rate_indicator = rate_q;
    assign stereo_sync_warning = swarn_q;
    assign card_sync_warning = cwarn_q;

    // ****************************************
    // Automatic source search
    // ****************************************

    // One source per cycle; the first usable external one is proposed
    always_comb begin
        scan_d = scan_q;
        case (scan_q)
            SCAN_IDLE: begin
                if (search_go) begin
                    scan_d = SCAN_RUN;
                end
            end
            SCAN_RUN: begin
                if (idx_q == 3'h5) begin
                    scan_d = SCAN_DONE;
                end
            end
            SCAN_DONE: scan_d = SCAN_IDLE;
            default: scan_d = SCAN_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_q <= SCAN_IDLE;
            idx_q <= 3'h0;
            found_q <= 1'b0;
            prop_q <= 3'h0;
        end else begin
            scan_q <= scan_d;
            if (scan_q == SCAN_IDLE && search_go) begin
                idx_q <= 3'h0;
                found_q <= 1'b0;
            end else if (scan_q == SCAN_RUN) begin
                idx_q <= idx_q + 3'h1;
                if (cand[idx_q] && !found_q) begin
                    found_q <= 1'b1;
                    prop_q <= idx_q + 3'h2;
                end
            end
        end
    end

    // ****************************************
    // Digital outputs
    // ****************************************
    logic [27:0] rnd;
    mix_pair_s st_src;
    dither_cfg_s st_cfg;
    out_pair_s cons_w;
    logic out_tick;

    // Noise runs freely so each sample sees a fresh value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_q <= `LFSR_SEED;
        end else begin
            lfsr_q <= {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        end
    end

    assign rnd = lfsr_q[27:0];
    assign out_tick = sel_tick && clock_locked;
    assign st_src = out_ctrl_q[`OC_TAP_BIT] ? after_fader_tap : stereo_bus_mix;
    assign st_cfg = '{dither: out_ctrl_q[`OC_SDITH_BIT],
        len: word_len_e'(out_ctrl_q[`OC_SWL_LSB +: 2])};

    // Same source and setting feed both stereo formats
    word_shortener #(.CAP(5'd24)) u_pro (
        .pclk(pclk),
        .presetn(presetn),
        .tick(out_tick),
        .cfg(st_cfg),
        .rnd(rnd),
        .smp(st_src),
        .q(stereo_output_pair)
    );

    word_shortener #(.CAP(5'd20)) u_cons (
        .pclk(pclk),
        .presetn(presetn),
        .tick(out_tick),
        .cfg(st_cfg),
        .rnd(rnd),
        .smp(st_src),
        .q(cons_w)
    );

    assign consumer_output_pair = {cons_w.left[23:4], cons_w.right[23:4]};

    // Each card pair has its own dither and length setting
    generate
        for (gi = 0; gi < 4; gi++) begin : g_card
            dither_cfg_s cfg_w;
            assign cfg_w = '{dither: out_ctrl_q[`OC_CARD_LSB + 3 * gi],
                len: word_len_e'(out_ctrl_q[`OC_CARD_LSB + 3 * gi + 1 +: 2])};
            word_shortener #(.CAP(5'd24)) u_card (
                .pclk(pclk),
                .presetn(presetn),
                .tick(out_tick),
                .cfg(cfg_w),
                .rnd(rnd),
                .smp(card_mix[gi]),
                .q(card_output[gi])
            );
        end
    endgenerate

endmodule : wordclock_select_dither_out

// File: shared/wordclock_consts.svh
// Register offsets, field positions, reset values and timing figures
`ifndef WORDCLOCK_CONSTS_SVH
`define WORDCLOCK_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_CLK_CTRL 12'h000
`define OFS_OUT_CTRL 12'h004
`define OFS_STATUS 12'h008

// ****************************************
// Field positions
// ****************************************
`define CC_SRC_LSB 0
`define CC_FLIP_BIT 3
`define CC_SWARN_BIT 4
`define CC_CWARN_BIT 5
`define CC_SEARCH_BIT 6
`define CC_WMASK 32'h0000_003F
`define OC_TAP_BIT 0
`define OC_SDITH_BIT 1
`define OC_SWL_LSB 2
`define OC_CARD_LSB 4
`define OC_WMASK 32'h0000_FFFF
`define ST_RATE_LSB 0
`define ST_LOCK_BIT 2
`define ST_SWARN_BIT 3
`define ST_CWARN_BIT 4
`define ST_BUSY_BIT 5
`define ST_FOUND_BIT 6
`define ST_PROP_LSB 8
`define ST_SRC_LSB 16

// ****************************************
// Reset values
// ****************************************
`define CC_RESET 32'h0000_0031
`define OC_RESET 32'h0000_2493
`define LFSR_SEED 32'h0000_0001

// ****************************************
// Timing
// ****************************************
`define PCLK_HZ 20000000
`define INT_RATE_A_HZ 44100
`define INT_RATE_B_HZ 48000
`define EXT_MIN_HZ 30080
`define EXT_MAX_HZ 50880
`define SPLIT_48_HZ 46000
`define SPLIT_32_HZ 38000
`define PER_MIN (`PCLK_HZ / `EXT_MAX_HZ)
`define PER_MAX ((`PCLK_HZ + `EXT_MIN_HZ - 1) / `EXT_MIN_HZ)
`define PER_SPLIT_48 (`PCLK_HZ / `SPLIT_48_HZ)
`define PER_SPLIT_32 (`PCLK_HZ / `SPLIT_32_HZ)
`define PER_INT_A (`PCLK_HZ / `INT_RATE_A_HZ)
`define PER_INT_B (`PCLK_HZ / `INT_RATE_B_HZ)
`define PER_TIMEOUT (2 * `PER_MAX)
`define SYNC_TOL 3
`define LOCK_PERIODS 4

`endif

// File: shared/wordclock_pkg.sv
// Types shared by the wordclock and digital output logic
package wordclock_pkg;

    // Clock source codes as software writes them
    typedef enum logic [2:0] {
        SRC_INT_44K1 = 3'h0,
        SRC_INTERNAL_CLOCK_48K = 3'h1,
        SRC_STEREO_IN = 3'h2,
        SRC_DEDICATED = 3'h3,
        SRC_CARD_12 = 3'h4,
        SRC_CARD_34 = 3'h5,
        SRC_CARD_56 = 3'h6,
        SRC_CARD_78 = 3'h7
    } clk_src_e;

    typedef enum logic [1:0] {
        ST_NONE = 2'h0,
        ST_NOT_SYNC = 2'h1,
        ST_USABLE = 2'h2,
        ST_LOCKED = 2'h3
    } src_state_e;

    typedef enum logic [1:0] {
        RATE_UNLOCK = 2'h0,
        RATE_32K = 2'h1,
        RATE_44K1 = 2'h2,
        RATE_48K = 2'h3
    } rate_code_e;

    typedef enum logic [1:0] {
        WL_24 = 2'h0,
        WL_20 = 2'h1,
        WL_16 = 2'h2,
        WL_24_ALT = 2'h3
    } word_len_e;

    typedef enum logic [2:0] {
        SCAN_IDLE = 3'b001,
        SCAN_RUN = 3'b010,
        SCAN_DONE = 3'b100
    } search_state_e;

    typedef struct packed {
        logic signed [27:0] left;
        logic signed [27:0] right;
    } mix_pair_s;

    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
    } out_pair_s;

    typedef struct packed {
        logic dither;
        word_len_e len;
    } dither_cfg_s;

    typedef struct packed {
        logic level;
        logic present;
        logic valid;
        logic rise;
        logic [10:0] period;
    } meter_s;

endpackage : wordclock_pkg

// File: tb/wc_source.sv
// Far-side device driving an external wordclock
module wc_source (
    output logic wc, // Wordclock pin
    input wire logic run, // Clock running
    input wire logic [15:0] half_ns // Half period
);
    timeunit 1ns;
    timeprecision 1ns;
    // Starts low; when stopped it holds whatever level it last drove
    initial wc = 1'b0;
    always begin
        if (run) begin
            #(half_ns) wc = ~wc;
        end else begin
            @(posedge run);
        end
    end
endmodule : wc_source

// File: tb/wordclock_select_dither_out_tb_top.sv
// Self-checking bench for the wordclock and digital output block
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("Error %0t: got %h exp %h", $time, g, e); end end
module wordclock_select_dither_out_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import wordclock_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, run, pready, pslverr, wc_pin, en, tick, lock;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed = 32'hA05F;
    logic [15:0] half;
    logic [15:0] hp [4] = '{16'd10417, 16'd11338, 16'd15625, 16'd200};
    logic [32:0] ex [4] = '{33'hC0007, 33'hC0006, 33'hC0005, 33'h40000};
    mix_pair_s bus, aft;
    mix_pair_s [3:0] card;
    out_pair_s pro;
    out_pair_s [3:0] cout;
    logic [39:0] con;
    logic [65:0] rq[$], r;
    logic [279:0] oq[$], o;
    int failures = 0, total_checks = 0;
    wordclock_select_dither_out i_wordclock_select_dither_out (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stereo_digital_input_clock(wc_pin),
        .dedicated_clock_input(wc_pin), .card_clock_in({4{wc_pin}}), .stereo_bus_mix(bus),
        .after_fader_tap(aft), .card_mix(card), .wordclock_out(), .wordclock_out_en(en),
        .sample_tick(tick), .clock_locked(lock), .unlocked_flag(), .sample_rate_indicator(),
        .stereo_sync_warning(), .card_sync_warning(), .stereo_output_pair(pro),
        .consumer_output_pair(con), .card_output(cout));
    wc_source i_wc_source (.wc(wc_pin), .run(run), .half_ns(half));
    // Clock, 50 ns period
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // APB transfer; request held until ready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
        rq.push_back({m, e});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic wl();
        for (int i = 0; i < 4000 && lock !== 1'b1; i++) @(posedge pclk);
    endtask : wl
    // New mix right after a tick, so the next strobe cannot catch it half set
    task automatic smp(input logic [31:0] oc);
        mix_pair_s b, f, c, s;
        while (tick !== 1'b1) @(posedge pclk);
        apb(1'b1, 12'h004, oc);
        b = 56'({rnd(), rnd()});
        f = 56'({rnd(), rnd()});
        c = 56'({rnd(), rnd()});
        s = oc[0] ? f : b;
        bus <= b;
        aft <= f;
        card <= {4{c}};
        oq.push_back({oc[2] ? {s.left[27:8], 4'h0, s.right[27:8], 4'h0} :
            {s.left[27:4], s.right[27:4]}, s.left[27:8], s.right[27:8],
            {4{c.left[27:4], c.right[27:4]}}});
        while (oq.size() > 0) @(posedge pclk);
    endtask : smp
    // Watcher: each finished read or sample is judged against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && rq.size() > 0) begin
            r = rq.pop_front();
            `CHK({pslverr, prdata} & r[65:33], r[32:0])
        end
        if (tick && oq.size() > 0) begin
            o = oq.pop_front();
            `CHK({pro, con, cout}, o)
        end
    end
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // Watchdog well beyond the expected run
    initial begin
        #3000000;
        failures++;
        test_done();
    end
    initial begin
        {psel, penable, pwrite, run, paddr, pwdata, bus, aft, card, presetn} = '0;
        half = 16'd10417;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h000, 33'h31, '1);
        rd(12'h004, 33'h2493, '1);
        rd(12'h00C, {1'b1, 32'h0}, '1);
        wl();
        rd(12'h008, 33'h7, 33'h7);
        `CHK(en, 1'b1)
        smp(32'h0);
        smp(32'h1);
        smp(32'h5);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h000, 32'h30);
            rd(12'h008, 33'h0, 33'h4);
            half <= hp[i];
            run <= 1'b1;
            apb(1'b1, 12'h000, 32'h33);
            wl();
            `CHK(en, 1'b0)
            rd(12'h008, ex[i], 33'hC0007);
        end
        half <= 16'd10417;
        apb(1'b1, 12'h000, 32'h38);
        wl();
        rd(12'h008, 33'h1001C, 33'h3001C);
        apb(1'b1, 12'h000, 32'h08);
        rd(12'h008, 33'h4, 33'h1C);
        apb(1'b1, 12'h000, 32'h40);
        repeat (8) @(posedge pclk);
        rd(12'h008, 33'h340, 33'h760);
        apb(1'b1, 12'h000, 32'h02);
        wl();
        rd(12'h008, 33'h0, 33'h4);
        apb(1'b1, 12'h000, 32'h0A);
        wl();
        rd(12'h008, 33'h7, 33'h7);
        test_done();
    end
endmodule : wordclock_select_dither_out_tb_top

// File: tb/wsdo_chk.sv
// Port-level assertions for the wordclock block
module wsdo_chk (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Write
    input wire logic [11:0] paddr, // Address
    input wire logic pslverr, // Error
    input wire logic wordclock_out_en, // Master
    input wire logic sample_tick, // Pulse
    input wire logic clock_locked, // Lock
    input wire logic unlocked_flag, // Unlock
    input wordclock_pkg::rate_code_e sample_rate_indicator, // Rate
    input wordclock_pkg::out_pair_s stereo_output_pair // Pair
);
    import wordclock_pkg::*;
    // Control write strobe; drive mode may only move after one
    wire logic cc_wr = psel && penable && pwrite && paddr == 12'h000;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // One cycle of grace, since rate code is registered apart from lock
    a_err_map: assert property (psel && penable && paddr == 12'h008 |-> !pslverr)
        else $error("status read errored");
    a_flag_inverse: assert property (unlocked_flag != clock_locked)
        else $error("unlock flag wrong");
    a_rate_locked: assert property (clock_locked [*2] |-> sample_rate_indicator != RATE_UNLOCK)
        else $error("no rate while locked");
    a_rate_unlock: assert property (!clock_locked [*2] |-> sample_rate_indicator == RATE_UNLOCK)
        else $error("rate while unlocked");
    a_tick_lock: assert property (sample_tick |-> clock_locked || $past(clock_locked))
        else $error("tick while unlocked");
    a_tick_gap: assert property (sample_tick |=> !sample_tick [*8])
        else $error("ticks too close");
    a_out_hold: assert property (!sample_tick |-> $stable(stereo_output_pair))
        else $error("output moved off tick");
    a_master_write: assert property ($changed(wordclock_out_en) |-> $past(cc_wr))
        else $error("master drive moved");
endmodule : wsdo_chk

bind wordclock_select_dither_out wsdo_chk i_wsdo_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pslverr, .wordclock_out_en, .sample_tick, .clock_locked, .unlocked_flag,
    .sample_rate_indicator, .stereo_output_pair);
